// [bridge_cmd_pkg.sv]
// Constants shared by the bridge-input command handler and its averager.
// Assumes a 100 MHz system clock and a controller that rewrites the output words each cycle.
package bridge_cmd_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 10;                  // System clock period
  localparam int unsigned CONV_SLOW_US      = 100000;              // 100 ms conversion period
  localparam int unsigned CONV_FAST_NS      = 12500000;            // 12.5 ms conversion period
  localparam int unsigned CONV_SLOW_CYCLES  = CONV_SLOW_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CONV_FAST_CYCLES  = CONV_FAST_NS / CLK_PERIOD_NS;
  // Command codes (command word bits 15..8)
  localparam logic [7:0] CMD_READ_VALUES    = 8'h00;
  localparam logic [6:0] CMD_READ_CFG_HI    = 7'h08;               // Upper seven bits of 1x00
  localparam logic [7:0] CMD_READ_MIN       = 8'h30;
  localparam logic [7:0] CMD_READ_MAX       = 8'h31;
  localparam logic [7:0] CMD_CLEAR_CH1      = 8'h32;
  localparam logic [7:0] CMD_CLEAR_CH2      = 8'h33;
  localparam logic [7:0] CMD_READ_ID        = 8'h3C;
  localparam logic [7:0] CMD_CONFIGURE      = 8'h40;
  // Parameter word fields
  localparam int unsigned AVG_LSB           = 9;
  localparam int unsigned CONV_BIT          = 4;
  localparam logic [15:0] PARAM_USED_MASK   = 16'h061F;
  localparam logic [3:0] RANGE_MAX_CODE     = 4'h5;
  // Reset values of a channel configuration
  localparam logic [1:0] AVG_RESET          = 2'h0;                // 16-sample mean
  localparam logic       CONV_RESET         = 1'b0;                // 100 ms
  localparam logic [3:0] RANGE_RESET        = 4'h1;                // 2 mV/V
  // Tracker and diagnostic values
  localparam logic [15:0] MIN_CLEAR         = 16'h7FFF;
  localparam logic [15:0] MAX_CLEAR         = 16'h8000;
  localparam logic [15:0] DIAG_INVALID      = 16'h8004;
  localparam logic [15:0] DIAG_LOW          = 16'h8000;
  localparam logic [15:0] DIAG_HIGH         = 16'h8100;
  localparam int unsigned STATUS_ERR_BIT    = 15;
  localparam int unsigned AVG_DEPTH_MAX     = 32;
endpackage

// [bridge_averager.sv]
// Moving-average buffer for one channel: keeps the last 32 samples and averages the newest N.
// Assumes samples arrive as single-cycle strobes from the converter on the same clock.
`timescale 1ns/1ns
module bridge_averager
  import bridge_cmd_pkg::*;
#(
  parameter int unsigned DEPTH = AVG_DEPTH_MAX
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  avg_mode,
  input  wire logic        flush,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  output logic             mean_valid,
  output logic [15:0]      mean_data
);
  initial begin
    if (DEPTH != AVG_DEPTH_MAX) $error("averager depth must be 32");
  end

  // Mode code to sample count: 00=16, 01=1, 10=4, 11=32
  function automatic logic [5:0] depth_of(input logic [1:0] m);
    unique case (m)
      2'b00: depth_of = 6'h10;
      2'b01: depth_of = 6'h01;
      2'b10: depth_of = 6'h04;
      2'b11: depth_of = 6'h20;
    endcase
  endfunction

  typedef struct packed {
    logic [31:0][15:0] ring;   // Newest sample at index wr-1
    logic [4:0]        wr;     // Write pointer
    logic [5:0]        fill;   // Samples held since flush
    logic              valid;  // One-cycle mean strobe
    logic [15:0]       mean;   // Last mean
  } avg_state_type;

  avg_state_type state_reg, state_next;
  logic [5:0]          n;
  logic signed [21:0]  acc;
  logic [4:0]          idx;

  // Sum of the newest N samples including the incoming one; a full window is needed first
  always_comb begin
    state_next = state_reg;
    n   = depth_of(avg_mode);
    acc = 22'(signed'(sample_data));
    idx = 5'h00;
    for (int i = 1; i < 32; i++) begin
      idx = state_reg.wr - 5'(i);
      if (6'(i) < n) acc = acc + 22'(signed'(state_reg.ring[idx]));
    end
    state_next.valid = 1'b0;
    if (flush) begin
      state_next.fill = 6'h00;  // Old samples belong to the old setting
    end else if (sample_valid) begin
      state_next.ring[state_reg.wr] = sample_data; // R13
      state_next.wr = state_reg.wr + 5'h01;
      if (state_reg.fill + 6'h01 >= n) begin
        state_next.valid = 1'b1;
        // Divide by a power of two; shift keeps the sign
        unique case (avg_mode)
          2'b00: state_next.mean = 16'(acc >>> 4); // R13
          2'b01: state_next.mean = 16'(acc);
          2'b10: state_next.mean = 16'(acc >>> 2);
          2'b11: state_next.mean = 16'(acc >>> 5);
        endcase
      end
      if (state_reg.fill != 6'h20) state_next.fill = state_reg.fill + 6'h01;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) state_reg <= '0;
    else state_reg <= state_next;
  end

  assign mean_valid = state_reg.valid;
  assign mean_data  = state_reg.mean;
endmodule

// [bridge_input_command_handler.sv]
// Command decoder, channel configuration, min/max trackers and input word mux of a two-channel
// bridge input. Assumes the converter front end delivers raw samples and error codes per channel.
// How it works
// R1 - Word 0 command, words 1-2 channel parameters
// R2 - Command in upper byte, low byte zero
// R3 - 1x00 returns channel C configuration
// R4 - 3000 returns both minimums
// R5 - 3100 returns both maximums
// R6 - 3200/3300 clear channel 1/2 trackers
// R7 - Clear loads min 7FFF, max 8000
// R8 - Controller clears trackers at acquisition start
// R9 - 3C00 returns firmware version and module ID
// R10 - Parameters evaluated only under command 4000
// R11 - Reserved parameter bits must be zero
// R12 - Averaging field decode 16/1/4/32 samples
// R13 - Output mean of newest N samples
// R14 - Bit 4 picks 100 or 12.5 ms
// R15 - Range codes 0-5 valid, others invalid
// R16 - Invalid parameters rejected, error flag set
// R17 - Configuration volatile, reset restores defaults
// R18 - Report 8004 until new measurement
// R19 - Default 16-sample, 100 ms, 2 mV/V
// R20 - Status: error bit 15, echo bits 14..8
// R21 - Read values: error flag groups channel errors
// R22 - Trackers compare each output as signed; the code skips diagnostic values 8001..80FF
`timescale 1ns/1ns
module bridge_input_command_handler
  import bridge_cmd_pkg::*;
#(
  parameter logic [7:0] FIRMWARE_VERSION = 8'h10,   // Arbitrary value
  parameter logic [7:0] MODULE_ID        = 8'h01,   // Arbitrary value
  parameter int unsigned SLOW_CYCLES     = CONV_SLOW_CYCLES,
  parameter int unsigned FAST_CYCLES     = CONV_FAST_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] command_word,
  input  wire logic [15:0] channel1_parameter_word,
  input  wire logic [15:0] channel2_parameter_word,
  input  wire logic [15:0] ch1_raw_sample,
  input  wire logic [15:0] ch2_raw_sample,
  output logic             ch1_convert,
  output logic             ch2_convert,
  output logic [3:0]       ch1_range,
  output logic [3:0]       ch2_range,
  output logic [15:0]      status_word_in,
  output logic [15:0]      input_word_one,
  output logic [15:0]      input_word_two
);
  initial begin
    if (SLOW_CYCLES < 2 || FAST_CYCLES < 2 || SLOW_CYCLES > 32'h3FFFFFFF)
      $error("conversion periods out of range");
  end

  // A channel configuration as the parameter word holds it
  typedef struct packed {
    logic [1:0] avg;     // Averaging mode
    logic       conv;    // Conversion period select
    logic [3:0] range;   // Measuring range
  } chan_cfg_type;

  typedef struct packed {
    chan_cfg_type [1:0] cfg;      // Live configuration
    logic [1:0][29:0]   timer;    // Conversion period counters
    logic [1:0]         conv;     // Converter strobes
    logic [1:0]         take;     // Result pickup, one cycle after each strobe
    logic [1:0][15:0]   meas;     // Output measured value
    logic [1:0][15:0]   min;      // Minimum trackers
    logic [1:0][15:0]   max;      // Maximum trackers
    logic [15:0]        last_cmd; // Previous command, to act on changes once
    logic [15:0]        status;   // Status word
    logic [15:0]        word1;    // Input word 1
    logic [15:0]        word2;    // Input word 2
  } handler_state_type;

  handler_state_type state_reg, state_next;
  logic [1:0]        mean_valid;
  logic [1:0][15:0]  mean_data;
  logic [1:0]        flush;
  logic [1:0][15:0]  param;
  logic [1:0]        param_ok;
  logic              cfg_ok;
  logic [7:0]        code;
  logic              new_cmd;
  logic              group_err;

  // Diagnostic window 8001..80FF marks an error value
  function automatic logic is_diag(input logic [15:0] v);
    is_diag = (v > DIAG_LOW) && (v < DIAG_HIGH);
  endfunction

  // Parameter word check: reserved bits clear and range code in table
  function automatic logic param_valid(input logic [15:0] p);
    param_valid = ((p & ~PARAM_USED_MASK) == 16'h0000) && (p[3:0] <= RANGE_MAX_CODE); // R11 R15
  endfunction

  // Decode parameter word into fields
  function automatic chan_cfg_type param_decode(input logic [15:0] p);
    param_decode.avg   = p[AVG_LSB +: 2]; // R12
    param_decode.conv  = p[CONV_BIT];     // R14
    param_decode.range = p[3:0];          // R15
  endfunction

  assign param[0] = channel1_parameter_word; // R1
  assign param[1] = channel2_parameter_word; // R1
  assign code     = command_word[15:8];      // R2
  assign new_cmd  = command_word != state_reg.last_cmd;
  assign param_ok[0] = param_valid(param[0]);
  assign param_ok[1] = param_valid(param[1]);
  assign cfg_ok      = &param_ok;

  // Averager restarts whenever a configuration takes effect
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      flush[c] = new_cmd && (code == CMD_CONFIGURE) && cfg_ok; // R18
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : chan
      bridge_averager #(
        .DEPTH (AVG_DEPTH_MAX)
      ) u_avg (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .avg_mode     (state_reg.cfg[g].avg),
        .flush        (flush[g]),
        .sample_valid (state_reg.take[g]),
        .sample_data  (g == 0 ? ch1_raw_sample : ch2_raw_sample),
        .mean_valid   (mean_valid[g]),
        .mean_data    (mean_data[g])
      );
    end
  endgenerate

  assign group_err = is_diag(state_reg.meas[0]) || is_diag(state_reg.meas[1]);

  // Next-state logic: timers, configuration, trackers and answer words
  always_comb begin
    state_next          = state_reg;
    state_next.last_cmd = command_word;
    // Conversion timing per channel
    for (int c = 0; c < 2; c++) begin
      state_next.conv[c] = 1'b0;
      // Converter result settles one cycle after its strobe, so pick it up then
      state_next.take[c] = state_reg.conv[c]; // R13
      if (state_reg.timer[c] == 30'h0) begin
        state_next.conv[c]  = 1'b1;
        state_next.timer[c] = state_reg.cfg[c].conv ? 30'(FAST_CYCLES - 1) : 30'(SLOW_CYCLES - 1); // R14
      end else begin
        state_next.timer[c] = state_reg.timer[c] - 30'h1;
      end
      // New mean becomes the measured value and, unless in the diagnostic window, feeds the trackers
      if (mean_valid[c]) begin
        state_next.meas[c] = mean_data[c];
        if (!is_diag(mean_data[c])) begin
          if ($signed(mean_data[c]) < $signed(state_reg.min[c])) state_next.min[c] = mean_data[c]; // R22
          if ($signed(mean_data[c]) > $signed(state_reg.max[c])) state_next.max[c] = mean_data[c]; // R22
        end
      end
    end
    // Tracker clears act once per command arrival
    if (new_cmd && code == CMD_CLEAR_CH1) begin
      state_next.min[0] = MIN_CLEAR; // R6 R7
      state_next.max[0] = MAX_CLEAR; // R6 R7
    end
    if (new_cmd && code == CMD_CLEAR_CH2) begin
      state_next.min[1] = MIN_CLEAR; // R6 R7
      state_next.max[1] = MAX_CLEAR; // R6 R7
    end
    // Configuration only under the configure command and only if both words are valid
    if (new_cmd && code == CMD_CONFIGURE && cfg_ok) begin // R10 R16
      for (int c = 0; c < 2; c++) begin
        state_next.cfg[c]   = param_decode(param[c]);
        state_next.meas[c]  = DIAG_INVALID; // R18
        state_next.timer[c] = 30'h0;        // Start converting at the new period at once
        state_next.conv[c]  = 1'b0;         // Drop a strobe of the old period
        state_next.take[c]  = 1'b0;         // Stale result never enters the new window
      end
    end
    // Answer words; status echoes bits 14..8 and leaves the low byte zero
    state_next.status = {1'b0, command_word[14:8], 8'h00}; // R20
    state_next.word1  = 16'h0000;
    state_next.word2  = 16'h0000;
    if (code == CMD_READ_VALUES) begin
      state_next.word1 = state_reg.meas[0];
      state_next.word2 = state_reg.meas[1];
      state_next.status[STATUS_ERR_BIT] = group_err; // R21
    end else if (code[7:1] == CMD_READ_CFG_HI) begin
      // Channel picked by command bit 8
      state_next.word1 = {5'h00, state_reg.cfg[code[0]].avg, 4'h0,
                          state_reg.cfg[code[0]].conv, state_reg.cfg[code[0]].range}; // R3
    end else if (code == CMD_READ_MIN) begin
      state_next.word1 = state_reg.min[0]; // R4
      state_next.word2 = state_reg.min[1]; // R4
    end else if (code == CMD_READ_MAX) begin
      state_next.word1 = state_reg.max[0]; // R5
      state_next.word2 = state_reg.max[1]; // R5
    end else if (code == CMD_READ_ID) begin
      state_next.word1 = {FIRMWARE_VERSION, MODULE_ID}; // R9
    end else if (code == CMD_CONFIGURE) begin
      // Error flag holds while the rejected command stays present
      state_next.status[STATUS_ERR_BIT] = !cfg_ok; // R16
    end else if (code != CMD_CLEAR_CH1 && code != CMD_CLEAR_CH2) begin
      state_next.status[STATUS_ERR_BIT] = 1'b1;  // Unknown command
    end
  end

  // State register; reset restores the default configuration
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg           <= '0;
      for (int c = 0; c < 2; c++) begin
        state_reg.cfg[c]  <= '{avg: AVG_RESET, conv: CONV_RESET, range: RANGE_RESET}; // R17 R19
        state_reg.meas[c] <= DIAG_INVALID;
        state_reg.min[c]  <= MIN_CLEAR;
        state_reg.max[c]  <= MAX_CLEAR;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  assign ch1_convert    = state_reg.conv[0];
  assign ch2_convert    = state_reg.conv[1];
  assign ch1_range      = state_reg.cfg[0].range;
  assign ch2_range      = state_reg.cfg[1].range;
  assign status_word_in = state_reg.status;
  assign input_word_one = state_reg.word1;
  assign input_word_two = state_reg.word2;
endmodule

// [bridge_converter_model.sv]
// Stand-in for one converter channel of the bridge front end.
// Assumes the handler strobes convert for one cycle and reads the result soon after.
`timescale 1ns/1ns
module bridge_converter_model (
  input  wire logic        sys_clk,
  input  wire logic        convert,
  input  wire logic [15:0] value,
  output logic [15:0]      raw_sample
);
  logic [1:0] hold_reg;  // Cycles the result stays valid

  initial begin
    hold_reg   = 2'h0;
    raw_sample = 16'h0000;
  end

  // Latch a result per strobe; the line toggles after the hold so stale data never looks valid
  always @(posedge sys_clk) begin
    if (convert) begin
      raw_sample <= value;
      hold_reg   <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end else begin
      raw_sample <= ~raw_sample;
    end
  end
endmodule

// [bridge_input_command_handler_asserts.sv]
// Port-level checks of the command handler answers and configuration.
// Assumes the one-cycle answer latency of the registered status and words.
`timescale 1ns/1ns
module bridge_input_command_handler_asserts
  import bridge_cmd_pkg::*;
#(
  parameter logic [7:0] FIRMWARE_VERSION = 8'h10,
  parameter logic [7:0] MODULE_ID        = 8'h01
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [15:0] command_word,
  input wire logic [15:0] channel1_parameter_word,
  input wire logic [15:0] channel2_parameter_word,
  input wire logic        ch1_convert,
  input wire logic [3:0]  ch1_range,
  input wire logic [3:0]  ch2_range,
  input wire logic [15:0] status_word_in,
  input wire logic [15:0] input_word_one
);
  import bridge_cmd_pkg::*;
  // Either parameter word carries a reserved bit or an unknown range
  wire logic bad = (|((channel1_parameter_word | channel2_parameter_word) & ~PARAM_USED_MASK))
                   || (channel1_parameter_word[3:0] > RANGE_MAX_CODE)
                   || (channel2_parameter_word[3:0] > RANGE_MAX_CODE);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_status_low_zero: assert property (status_word_in[7:0] == 8'h00) else $error("status low byte set");
  a_status_echo: assert property ($past(rst_n) |-> status_word_in[14:8] == $past(command_word[14:8]))
    else $error("status echo wrong");
  a_id_answer: assert property ($past(rst_n) && $past(command_word) == 16'h3C00
    |-> input_word_one == {FIRMWARE_VERSION, MODULE_ID}) else $error("id answer wrong");
  a_cfg_readback: assert property ($past(rst_n) && $past(command_word[15:9]) == 7'h08
    |-> (input_word_one & ~PARAM_USED_MASK) == 16'h0000) else $error("config readback has stray bits");
  a_cfg_flag: assert property ($past(rst_n) && $past(command_word) == 16'h4000
    |-> status_word_in[15] == $past(bad)) else $error("config error flag wrong");
  a_range_hold: assert property ($past(rst_n) && $past(command_word) != 16'h4000
    && $past(command_word, 2) != 16'h4000 |-> $stable(ch1_range) && $stable(ch2_range)) else $error("range moved");
  a_range_legal: assert property (ch1_range <= RANGE_MAX_CODE && ch2_range <= RANGE_MAX_CODE)
    else $error("illegal range applied");
  a_convert_pulse: assert property (ch1_convert |=> !ch1_convert) else $error("convert strobe too long");

  c_cfg_ok: cover property ($past(command_word) == 16'h4000 && !status_word_in[15]);
  c_cfg_bad: cover property ($past(command_word) == 16'h4000 && status_word_in[15]);
  c_id: cover property ($past(command_word) == 16'h3C00);
endmodule

bind bridge_input_command_handler bridge_input_command_handler_asserts #(
  .FIRMWARE_VERSION(FIRMWARE_VERSION),
  .MODULE_ID(MODULE_ID)
) u_asserts (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .command_word(command_word),
  .channel1_parameter_word(channel1_parameter_word),
  .channel2_parameter_word(channel2_parameter_word),
  .ch1_convert(ch1_convert),
  .ch1_range(ch1_range),
  .ch2_range(ch2_range),
  .status_word_in(status_word_in),
  .input_word_one(input_word_one)
);

// [bridge_input_command_handler_bench.sv]
// Self-checking bench for the bridge input command handler.
// Assumes shortened conversion periods (40 and 10 cycles) to keep the run short.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module bridge_input_command_handler_bench;
  import bridge_cmd_pkg::*;
  typedef struct {logic [15:0] st; logic [15:0] w1; logic [15:0] w2; bit two;} note_type;
  logic        sys_clk, rst_n, ch1_convert, ch2_convert;
  logic [15:0] command_word, channel1_parameter_word, channel2_parameter_word;
  logic [15:0] ch1_raw_sample, ch2_raw_sample, ch2_value;
  logic [15:0] status_word_in, input_word_one, input_word_two, last_cmd;
  logic [3:0]  ch1_range, ch2_range;
  logic [15:0] cfg [2];    // Expected stored configuration
  logic [15:0] p [2];      // Parameter words under test
  logic [15:0] vals [4];   // Channel 1 samples, cycled per conversion
  note_type    notes [$];  // Expected answers, oldest first
  note_type    cur;
  event        probe;
  int          n_errors, checked, n_conv, sum;
  // Sample index restarts when a configure command is first seen
  wire logic [15:0] ch1_value = vals[n_conv[1:0]];

  bridge_input_command_handler #(.SLOW_CYCLES(40), .FAST_CYCLES(10)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .command_word(command_word),
    .channel1_parameter_word(channel1_parameter_word), .channel2_parameter_word(channel2_parameter_word),
    .ch1_raw_sample(ch1_raw_sample), .ch2_raw_sample(ch2_raw_sample),
    .ch1_convert(ch1_convert), .ch2_convert(ch2_convert), .ch1_range(ch1_range), .ch2_range(ch2_range),
    .status_word_in(status_word_in), .input_word_one(input_word_one), .input_word_two(input_word_two));
  bridge_converter_model u_conv1 (.sys_clk(sys_clk), .convert(ch1_convert), .value(ch1_value),
    .raw_sample(ch1_raw_sample));
  bridge_converter_model u_conv2 (.sys_clk(sys_clk), .convert(ch2_convert), .value(ch2_value),
    .raw_sample(ch2_raw_sample));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Count channel 1 conversions since the last configure
  always @(posedge sys_clk) begin
    last_cmd <= command_word;
    if (command_word == 16'h4000 && last_cmd != 16'h4000) n_conv <= 0;
    else if (ch1_convert) n_conv <= n_conv + 1;
  end

  // Compare the oldest note once the driver says the answer has settled
  always @(probe) begin
    cur = notes.pop_front();
    `CHK(status_word_in, cur.st)
    `CHK(input_word_one, cur.w1)
    if (cur.two) `CHK(input_word_two, cur.w2)
  end

  task automatic put(input logic [15:0] c, input logic [15:0] p1, input logic [15:0] p2);
    @(negedge sys_clk);
    command_word = c;
    channel1_parameter_word = p1;
    channel2_parameter_word = p2;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic note(input logic [15:0] st, input logic [15:0] w1, input logic [15:0] w2, input bit two);
    notes.push_back('{st, w1, w2, two});
    -> probe;
  endtask

  // Readback of both configurations with junk parameters
  task automatic readback();
    for (int i = 0; i < 2; i++) begin
      put({7'h08, i[0], 8'h00}, 16'($urandom), 16'($urandom));
      note({7'h08, i[0], 8'h00}, cfg[i], 16'h0000, 1'b0);
    end
  endtask

  task automatic defaults();
    cfg = '{16'h0001, 16'h0001};
    readback();
    put(16'h3000, 16'h0000, 16'h0000);
    note(16'h3000, MIN_CLEAR, MIN_CLEAR, 1'b1);
    put(16'h3100, 16'h0000, 16'h0000);
    note(16'h3100, MAX_CLEAR, MAX_CLEAR, 1'b1);
    put(16'h3C00, 16'h0000, 16'h0000);
    note(16'h3C00, 16'h1001, 16'h0000, 1'b0);
    put(16'h2000, 16'h0000, 16'h0000);
    note(16'hA000, 16'h0000, 16'h0000, 1'b1);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hF7E4));
    rst_n = 1'b0;
    command_word = 16'h0000;
    channel1_parameter_word = 16'h0000;
    channel2_parameter_word = 16'h0000;
    ch2_value = 16'h0000;
    n_conv = 0;
    vals = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    defaults();
    // Valid configurations, then a bad range and reserved bits in either word
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 2; c++) p[c] = {5'h00, 2'($urandom), 4'h0, 1'($urandom), 4'($urandom_range(0, 5))};
      if (i == 5) p[0][3:0] = 4'($urandom_range(6, 15));
      if (i == 6) p[1][5] = 1'b1;
      if (i == 7) p[0] = p[0] | (16'h0800 << ($urandom % 5));
      put(16'h4000, p[0], p[1]);
      note({i >= 5, 15'h4000}, 16'h0000, 16'h0000, 1'b1);
      if (i < 5) cfg = p;
      readback();
      `CHK(ch1_range, cfg[0][3:0])
      `CHK(ch2_range, cfg[1][3:0])
    end
    @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    defaults();
    // Four-sample mean on channel 1, no averaging on channel 2, fast conversions
    sum = 0;
    for (int k = 0; k < 4; k++) begin
      vals[k] = 16'($urandom_range(0, 50000) - 25000);
      sum += int'($signed(vals[k]));
    end
    ch2_value = 16'($urandom_range(0, 50000) - 25000);
    put(16'h4000, 16'h0410, 16'h0210);
    put(16'h0000, 16'h0000, 16'h0000);
    note(16'h8000, DIAG_INVALID, 16'h0000, 1'b0);
    wait (n_conv == 3);
    repeat (4) @(negedge sys_clk);
    note(16'h8000, DIAG_INVALID, ch2_value, 1'b1);
    wait (n_conv == 4);
    repeat (4) @(negedge sys_clk);
    note(16'h0000, 16'(sum >>> 2), ch2_value, 1'b1);
    // Clear each channel just after a conversion so no new sample lands first
    @(posedge sys_clk iff ch1_convert);
    repeat (2) @(negedge sys_clk);
    put(16'h3200, 16'h0000, 16'h0000);
    put(16'h3000, 16'h0000, 16'h0000);
    note(16'h3000, MIN_CLEAR, ch2_value, 1'b1);
    @(posedge sys_clk iff ch1_convert);
    repeat (2) @(negedge sys_clk);
    put(16'h3300, 16'h0000, 16'h0000);
    put(16'h3100, 16'h0000, 16'h0000);
    note(16'h3100, 16'(sum >>> 2), MAX_CLEAR, 1'b1);
    print_verdict();
  end
endmodule
